// >>> dei_top.sv
/*
 * Event status and interrupt-request logic of the dual converter: three
 * write-one-to-clear status registers, lane buffer flag readback, the lane
 * buffer error tracker and the active-low interrupt output.
 * Assumes all inputs are synchronous to i_clk and that the register port
 * strobes are single-cycle pulses from the serial control port decoder.
 */
`timescale 1ns/100ps
`include "dei_regs.svh"
module dei_top #(
    parameter int LANES = 8
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,

    // Register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [11:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,

    // Sticky mode settings, one bit per status bit position
    input  wire logic [7:0]  i_sticky_clock_fifo,
    input  wire logic [7:0]  i_sticky_pattern,
    input  wire logic [7:0]  i_sticky_ch0,

    // Clock multiplier conditions
    input  wire logic        i_conv_pll_lost,
    input  wire logic        i_conv_pll_locked,
    input  wire logic        i_lane_pll_lost,
    input  wire logic        i_lane_pll_locked,

    // Serial link and lane buffers
    input  wire logic        i_link_en,
    input  wire logic [LANES-1:0] i_lane_full,
    input  wire logic [LANES-1:0] i_lane_empty,

    // Channel conditions
    input  wire logic        i_pattern_fail_ch0,
    input  wire logic        i_pattern_fail_ch1,
    input  wire logic        i_power_threshold_ch0,
    input  wire logic        i_blanking_complete_ch0,
    input  wire logic        i_align_locked_ch0,
    input  wire logic        i_align_rotated_ch0,
    input  wire logic        i_align_out_of_window_ch0,
    input  wire logic        i_align_tripped_ch0,

    // Interrupt request and lane buffer error level
    output logic             o_irq_n,
    output logic             o_lane_buffer_error_flag
);

    // Lane flags share one readback byte each, so more than eight lanes cannot be shown.
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
        $error("LANES must lie between 1 and 8");
    end

    dei_bank_if clock_fifo_if ();
    dei_bank_if pattern_if ();
    dei_bank_if ch0_if ();

    dei_pkg::dei_link_state_t link_state_q;
    logic [7:0]               lane_full_q;
    logic [7:0]               lane_empty_q;
    logic                     lane_fault;
    logic                     wr_clock_fifo;
    logic                     wr_pattern;
    logic                     wr_ch0;
    dei_pkg::dei_byte_t       rd_mux;

    // Address match; used by both the write-clear and the read decoding.
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = (addr == off);
    endfunction

    // Any full or empty lane buffer counts as a fault while the link runs.
    assign lane_fault = (|i_lane_full) | (|i_lane_empty); // RULE_08

    // Lane buffer error tracker. Once faulted it stays faulted until the link
    // is turned off; re-enabling then starts a clean run.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            link_state_q <= dei_pkg::LINK_OFF;
        end else begin
            case (link_state_q)
                dei_pkg::LINK_OFF: begin
                    if (i_link_en) begin
                        link_state_q <= dei_pkg::LINK_RUNNING;
                    end
                end
                dei_pkg::LINK_RUNNING: begin
                    if (!i_link_en) begin
                        link_state_q <= dei_pkg::LINK_OFF;
                    end else if (lane_fault) begin
                        link_state_q <= dei_pkg::LINK_FAULTED; // RULE_08
                    end
                end
                dei_pkg::LINK_FAULTED: begin
                    if (!i_link_en) begin
                        link_state_q <= dei_pkg::LINK_OFF; // RULE_09
                    end
                end
                default: begin
                    link_state_q <= dei_pkg::LINK_OFF;
                end
            endcase
        end
    end

    // Live lane buffer error level, also brought out for the link logic.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_lane_buffer_error_flag <= 1'b0;
        end else begin
            o_lane_buffer_error_flag <= (link_state_q == dei_pkg::LINK_FAULTED); // RULE_09
        end
    end

    // Snapshot of the per-lane flags so software can find the lane at fault.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lane_full_q  <= 8'h00;
            lane_empty_q <= 8'h00;
        end else begin
            lane_full_q  <= 8'(i_lane_full); // RULE_10
            lane_empty_q <= 8'(i_lane_empty); // RULE_10
        end
    end

    // Write strobes of the three clearable registers.
    assign wr_clock_fifo = i_reg_wr & addr_hit(i_reg_addr, `DEI_OFF_CLOCK_FIFO);
    assign wr_pattern    = i_reg_wr & addr_hit(i_reg_addr, `DEI_OFF_PATTERN_CHECK);
    assign wr_ch0        = i_reg_wr & addr_hit(i_reg_addr, `DEI_OFF_CH0_EVENTS);

    // Clock multiplier and lane buffer bank.
    always_comb begin
        clock_fifo_if.cond = 8'h00;
        clock_fifo_if.cond[`DEI_BIT_CONV_PLL_LOST]   = i_conv_pll_lost; // RULE_04
        clock_fifo_if.cond[`DEI_BIT_CONV_PLL_LOCKED] = i_conv_pll_locked; // RULE_05
        clock_fifo_if.cond[`DEI_BIT_LANE_PLL_LOST]   = i_lane_pll_lost; // RULE_06
        clock_fifo_if.cond[`DEI_BIT_LANE_PLL_LOCKED] = i_lane_pll_locked; // RULE_07
        clock_fifo_if.cond[`DEI_BIT_LANE_BUF_ERR]    = (link_state_q == dei_pkg::LINK_FAULTED); // RULE_08
    end
    assign clock_fifo_if.sticky = i_sticky_clock_fifo; // RULE_06
    assign clock_fifo_if.clr    = wr_clock_fifo ? i_reg_wdata : 8'h00; // RULE_03

    // Pattern check bank.
    always_comb begin
        pattern_if.cond = 8'h00;
        pattern_if.cond[`DEI_BIT_PATTERN_CH1] = i_pattern_fail_ch1; // RULE_11
        pattern_if.cond[`DEI_BIT_PATTERN_CH0] = i_pattern_fail_ch0; // RULE_12
    end
    assign pattern_if.sticky = i_sticky_pattern; // RULE_11
    assign pattern_if.clr    = wr_pattern ? i_reg_wdata : 8'h00; // RULE_03

    // Channel 0 event bank.
    always_comb begin
        ch0_if.cond = 8'h00;
        ch0_if.cond[`DEI_BIT_POWER_CH0]      = i_power_threshold_ch0; // RULE_13
        ch0_if.cond[`DEI_BIT_BLANK_CH0]      = i_blanking_complete_ch0; // RULE_14
        ch0_if.cond[`DEI_BIT_ALIGN_LOCK_CH0] = i_align_locked_ch0; // RULE_15
        ch0_if.cond[`DEI_BIT_ALIGN_ROT_CH0]  = i_align_rotated_ch0; // RULE_16
        ch0_if.cond[`DEI_BIT_ALIGN_WIN_CH0]  = i_align_out_of_window_ch0; // RULE_17
        ch0_if.cond[`DEI_BIT_ALIGN_TRIP_CH0] = i_align_tripped_ch0; // RULE_18
    end
    assign ch0_if.sticky = i_sticky_ch0; // RULE_18
    assign ch0_if.clr    = wr_ch0 ? i_reg_wdata : 8'h00; // RULE_03

    dei_status_bank #(
        .VALID (`DEI_VALID_CLOCK_FIFO)
    ) u_bank_clock_fifo (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (clock_fifo_if)
    );

    dei_status_bank #(
        .VALID (`DEI_VALID_PATTERN_CHECK)
    ) u_bank_pattern (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (pattern_if)
    );

    dei_status_bank #(
        .VALID (`DEI_VALID_CH0_EVENTS)
    ) u_bank_ch0 (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (ch0_if)
    );

    // Read selection; unmapped addresses return zero.
    always_comb begin
        rd_mux = 8'h00;
        if (addr_hit(i_reg_addr, `DEI_OFF_CLOCK_FIFO)) begin
            rd_mux = clock_fifo_if.status;
        end else if (addr_hit(i_reg_addr, `DEI_OFF_PATTERN_CHECK)) begin
            rd_mux = pattern_if.status; // RULE_20
        end else if (addr_hit(i_reg_addr, `DEI_OFF_CH0_EVENTS)) begin
            rd_mux = ch0_if.status;
        end else if (addr_hit(i_reg_addr, `DEI_OFF_LANE_FULL)) begin
            rd_mux = lane_full_q; // RULE_10
        end else if (addr_hit(i_reg_addr, `DEI_OFF_LANE_EMPTY)) begin
            rd_mux = lane_empty_q; // RULE_10
        end
    end

    // Read data is registered so the port never sees a combinational path.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_mux;
            end
        end
    end

    // Interrupt output, low while anything is latched; one cycle behind the latch.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= ~(clock_fifo_if.pending | pattern_if.pending | ch0_if.pending); // RULE_02 RULE_19
        end
    end

endmodule

// >>> dei_regs.svh
/*
 * Register offsets, bit positions, reserved-bit masks and reset values of the
 * event status and interrupt-request block of the dual converter.
 * Assumes it is included by bare name from the design modules, the checker and the bench.
 */
// Contract
// RULE_01: Sticky mode low: status bit follows live condition, no latch, no interrupt.
// RULE_02: Sticky mode high: rising edge latches bit and pulls interrupt output low.
// RULE_03: Latched bit clears only on write of 1; write 0 keeps; reset zero. The code also clears it while its sticky mode is low.
// RULE_04: Converter clock multiplier lock loss reads as 1 in its lost bit.
// RULE_05: Converter clock multiplier locked reads as 1 in bit 4.
// RULE_06: Lane PLL lock loss reads as 1 in bit 3, own sticky control.
// RULE_07: Lane PLL locked reads as 1 in bit 2.
// RULE_08: Lane buffer error in bit 1 on any lane FIFO full or empty.
// RULE_09: Lane buffer error persists until link is disabled and re-enabled.
// RULE_10: Per-lane full flags at 0x30C, per-lane empty flags at 0x30D.
// RULE_11: Channel 1 pattern failure sets bit 2 of 0x024; bits 7 to 3 reserved.
// RULE_12: Channel 0 pattern failure sets bit 0 of 0x024; bit 1 reserved.
// RULE_13: Channel 0 over power threshold sets bit 7 of 0x025.
// RULE_14: Channel 0 blanking done sets bit 5 of 0x025; bits 6, 4 reserved.
// RULE_15: Channel 0 alignment locked sets bit 3 of 0x025.
// RULE_16: Channel 0 alignment rotated sets bit 2 of 0x025.
// RULE_17: Channel 0 phase outside window sets bit 1 of 0x025.
// RULE_18: Channel 0 alignment tripped sets bit 0 of 0x025, own sticky control.
// RULE_19: Interrupt output stays low while any latched bit is set.
// RULE_20: Reserved status bits read zero and ignore writes.
`ifndef DEI_REGS_SVH
`define DEI_REGS_SVH

`define DEI_ADDR_W              12
`define DEI_DATA_W              8

`define DEI_OFF_CLOCK_FIFO      12'h023
`define DEI_OFF_PATTERN_CHECK   12'h024
`define DEI_OFF_CH0_EVENTS      12'h025
`define DEI_OFF_LANE_FULL       12'h30C
`define DEI_OFF_LANE_EMPTY      12'h30D

`define DEI_STATUS_RESET        8'h00

`define DEI_BIT_CONV_PLL_LOST   5
`define DEI_BIT_CONV_PLL_LOCKED 4
`define DEI_BIT_LANE_PLL_LOST   3
`define DEI_BIT_LANE_PLL_LOCKED 2
`define DEI_BIT_LANE_BUF_ERR    1

`define DEI_BIT_PATTERN_CH1     2
`define DEI_BIT_PATTERN_CH0     0

`define DEI_BIT_POWER_CH0       7
`define DEI_BIT_BLANK_CH0       5
`define DEI_BIT_ALIGN_LOCK_CH0  3
`define DEI_BIT_ALIGN_ROT_CH0   2
`define DEI_BIT_ALIGN_WIN_CH0   1
`define DEI_BIT_ALIGN_TRIP_CH0  0

`define DEI_VALID_CLOCK_FIFO    8'h3E
`define DEI_VALID_PATTERN_CHECK 8'h05
`define DEI_VALID_CH0_EVENTS    8'hAF

`endif

// >>> dei_pkg.sv
/*
 * Types shared by the event status block.
 * Assumes nothing beyond the constants header.
 */
package dei_pkg;

    // Progress of the serial link as seen by the lane buffer error tracker.
    typedef enum {
        LINK_OFF,
        LINK_RUNNING,
        LINK_FAULTED
    } dei_link_state_t;

    typedef logic [7:0] dei_byte_t;

endpackage

// >>> dei_bank_if.sv
/*
 * Carrier between the top module and one bank of eight status bits.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface dei_bank_if;
    logic [7:0] cond;
    logic [7:0] sticky;
    logic [7:0] clr;
    logic [7:0] status;
    logic       pending;

    modport ctrl (output cond, output sticky, output clr, input status, input pending);
    modport bank (input cond, input sticky, input clr, output status, output pending);
endinterface

// >>> dei_status_bank.sv
/*
 * One eight-bit status register with per-bit live or sticky behaviour.
 * Assumes conditions, sticky settings and clear masks are synchronous to i_clk.
 */
`timescale 1ns/100ps
`include "dei_regs.svh"
module dei_status_bank #(
    parameter logic [7:0] VALID = 8'hFF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Bank carrier
    dei_bank_if.bank bus
);
    logic [7:0] prev_q;
    logic [7:0] latch_q;

    // Previous condition, kept for rising-edge detection.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            prev_q <= `DEI_STATUS_RESET;
        end else begin
            prev_q <= bus.cond & VALID;
        end
    end

    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bit
            if (VALID[b]) begin : g_used
                // The set term is OR-ed after the clear, so an edge in a clearing cycle is kept.
                always_ff @(posedge i_clk) begin
                    if (!i_rstn) begin
                        latch_q[b] <= 1'b0; // RULE_03
                    end else if (!bus.sticky[b]) begin
                        latch_q[b] <= 1'b0; // RULE_01
                    end else begin
                        latch_q[b] <= (latch_q[b] & ~bus.clr[b]) | (bus.cond[b] & ~prev_q[b]); // RULE_02 RULE_03
                    end
                end
                assign bus.status[b] = bus.sticky[b] ? latch_q[b] : bus.cond[b]; // RULE_01 RULE_02
            end else begin : g_rsvd
                // Reserved positions keep only a flop with no reset that loads zero on every clock.
                always_ff @(posedge i_clk) begin
                    latch_q[b] <= 1'b0;
                end
                assign bus.status[b] = 1'b0; // RULE_20
            end
        end
    endgenerate

    // Only latched bits request an interrupt.
    assign bus.pending = |latch_q; // RULE_19
endmodule

// >>> dei_assertions.sv
/*
 * Concurrent checks on the ports of the event status block.
 * Assumes one clock domain and a bind onto every instance of dei_top.
 */
`timescale 1ns/100ps
`include "dei_regs.svh"
module dei_assertions #(
    parameter int LANES = 8
) (
    // Clock, reset and register port
    input wire logic             i_clk,
    input wire logic             i_rstn,
    input wire logic             i_reg_wr,
    input wire logic             i_reg_rd,
    input wire logic [11:0]      i_reg_addr,
    input wire logic [7:0]       i_reg_wdata,
    input wire logic [7:0]       o_reg_rdata,
    input wire logic             o_reg_rvalid,
    // Sticky settings
    input wire logic [7:0]       i_sticky_clock_fifo,
    input wire logic [7:0]       i_sticky_pattern,
    input wire logic [7:0]       i_sticky_ch0,
    // Link and channel conditions
    input wire logic             i_link_en,
    input wire logic [LANES-1:0] i_lane_full,
    input wire logic [LANES-1:0] i_lane_empty,
    input wire logic             i_power_threshold_ch0,
    input wire logic             i_blanking_complete_ch0,
    input wire logic             i_align_locked_ch0,
    input wire logic             i_align_rotated_ch0,
    input wire logic             i_align_out_of_window_ch0,
    input wire logic             i_align_tripped_ch0,
    // Outputs
    input wire logic             o_irq_n,
    input wire logic             o_lane_buffer_error_flag
);
    // Channel 0 conditions placed at their status bit positions, reserved bits zero.
    logic [7:0]  ch0_live;
    logic [23:0] sticky_all;
    assign ch0_live = {i_power_threshold_ch0, 1'b0, i_blanking_complete_ch0, 1'b0, i_align_locked_ch0,
                       i_align_rotated_ch0, i_align_out_of_window_ch0, i_align_tripped_ch0};
    assign sticky_all = {i_sticky_clock_fifo, i_sticky_pattern, i_sticky_ch0};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // A sticky trip edge that no write can undo on the following cycle.
    sequence s_trip_rise;
        $rose(i_align_tripped_ch0) && i_sticky_ch0[0] ##1 !i_reg_wr && i_sticky_ch0[0];
    endsequence
    // A full clear of the channel 0 bank followed by a read with all conditions quiet.
    sequence s_clear_then_read;
        i_reg_wr && i_reg_addr == `DEI_OFF_CH0_EVENTS && i_reg_wdata == 8'hFF && ch0_live == 8'h00
        ##1 ch0_live == 8'h00 ##1 i_reg_rd && i_reg_addr == `DEI_OFF_CH0_EVENTS && ch0_live == 8'h00;
    endsequence

    trip_sets_irq_a: assert property (s_trip_rise |=> !o_irq_n)
        else $error("Latched trip edge did not pull the interrupt low.");
    irq_holds_a: assert property ((!i_reg_wr && $stable(sticky_all))[*2] ##0 !o_irq_n |=> !o_irq_n)
        else $error("Interrupt released without a clear.");
    live_no_irq_a: assert property ((sticky_all == 24'h000000)[*4] |-> o_irq_n)
        else $error("Interrupt asserted with every bit in live mode.");
    live_read_a: assert property (i_reg_rd && i_reg_addr == `DEI_OFF_CH0_EVENTS && i_sticky_ch0 == 8'h00
        && $past(i_sticky_ch0) == 8'h00 && $stable(ch0_live) |=> o_reg_rdata == $past(ch0_live))
        else $error("Live channel 0 status differs from its conditions.");
    clear_read_a: assert property (s_clear_then_read |=> o_reg_rdata == 8'h00)
        else $error("Cleared channel 0 bits still read as set.");
    reserved_zero_a: assert property (i_reg_rd && i_reg_addr == `DEI_OFF_CH0_EVENTS
        |=> (o_reg_rdata & ~`DEI_VALID_CH0_EVENTS) == 8'h00)
        else $error("Reserved channel 0 bits read nonzero.");
    rvalid_follows_a: assert property (1'b1 |=> o_reg_rvalid == $past(i_reg_rd))
        else $error("Read valid does not follow the read strobe.");
    full_readback_a: assert property (i_reg_rd && i_reg_addr == `DEI_OFF_LANE_FULL && $stable(i_lane_full)
        |=> o_reg_rdata == 8'($past(i_lane_full)))
        else $error("Lane full readback wrong.");
    buf_err_set_a: assert property ($past(i_rstn) && $past(i_link_en) && i_link_en
        && (|i_lane_full || |i_lane_empty) ##1 i_link_en |=> o_lane_buffer_error_flag)
        else $error("Lane buffer fault not flagged.");
    buf_err_hold_a: assert property (o_lane_buffer_error_flag && i_link_en && $past(i_link_en)
        |=> o_lane_buffer_error_flag)
        else $error("Lane buffer error dropped while the link stayed on.");
    buf_err_drop_a: assert property ((!i_link_en)[*2] |=> !o_lane_buffer_error_flag)
        else $error("Lane buffer error kept with the link off.");
endmodule

bind dei_top dei_assertions #(.LANES(LANES)) u_chk (.*);

// >>> test_dac_event_status_irq.sv
/*
 * Self-checking bench for the event status block: live, sticky and lane buffer behaviour.
 * Assumes dei_top with its default lane count, a 20 MHz clock and the checker bound beside it.
 */
`timescale 1ns/100ps
`include "dei_regs.svh"
module test_dac_event_status_irq;
    // Design ports; conditions are kept in vectors at their status bit positions.
    logic        i_clk, i_rstn, i_reg_wr, i_reg_rd, i_link_en, o_reg_rvalid, o_irq_n, o_lane_buffer_error_flag;
    logic [11:0] i_reg_addr;
    logic [7:0]  i_reg_wdata, o_reg_rdata, i_sticky_clock_fifo, i_sticky_pattern, i_sticky_ch0;
    logic [7:0]  i_lane_full, i_lane_empty, clk_c, pat_c, ch0_c;
    logic        i_conv_pll_lost, i_conv_pll_locked, i_lane_pll_lost, i_lane_pll_locked;
    logic        i_pattern_fail_ch0, i_pattern_fail_ch1, i_power_threshold_ch0, i_blanking_complete_ch0;
    logic        i_align_locked_ch0, i_align_rotated_ch0, i_align_out_of_window_ch0, i_align_tripped_ch0;
    int          n_mismatch, compares;
    logic [7:0]  exp_q[$];

    // Spread the condition vectors onto the single-bit inputs.
    assign {i_conv_pll_lost, i_conv_pll_locked, i_lane_pll_lost, i_lane_pll_locked} = clk_c[5:2];
    assign {i_pattern_fail_ch1, i_pattern_fail_ch0} = {pat_c[2], pat_c[0]};
    assign {i_power_threshold_ch0, i_blanking_complete_ch0} = {ch0_c[7], ch0_c[5]};
    assign {i_align_locked_ch0, i_align_rotated_ch0, i_align_out_of_window_ch0, i_align_tripped_ch0} = ch0_c[3:0];

    dei_top dut (.*);

    // Free-running 50 ns clock.
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: read 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic cmp_lvl(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: level %b expected %b", $time, got, exp);
        end
    endtask

    // One strobe cycle then one idle cycle, so a strobe is never assigned twice at one edge.
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        exp_q.push_back(e);
        tick(1);
        i_reg_rd <= 1'b0;
        tick(1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        tick(1);
        i_reg_wr <= 1'b0;
        tick(1);
    endtask

    task automatic final_report();
        // A read that was never answered is a failure, not a silent skip.
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("ERROR %0t: %0d read answers missing", $time, exp_q.size());
        end
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Every read answer takes the oldest expectation off the queue.
    always @(posedge i_clk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("ERROR %0t: read answer without a request", $time);
            end else cmp_byte(o_reg_rdata, exp_q.pop_front());
        end
    end

    // Cuts a hang short; the whole sequence needs well under a thousand cycles.
    initial begin
        tick(5000);
        n_mismatch++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence: reset values, live mode, sticky latching and clearing, lane buffer fault.
    initial begin
        int         k;
        logic [7:0] r;
        {i_rstn, i_reg_wr, i_reg_rd, i_link_en} = 4'h0;
        {i_reg_addr, i_reg_wdata} = 20'h00000;
        {i_sticky_clock_fifo, i_sticky_pattern, i_sticky_ch0} = 24'h000000;
        {i_lane_full, i_lane_empty, clk_c, pat_c, ch0_c} = 40'h0000000000;
        void'($urandom(32'hE31A3FAA));
        tick(16);
        i_rstn <= 1'b1;
        tick(1);
        cmp_lvl(o_irq_n, 1'b1);
        rd(`DEI_OFF_CLOCK_FIFO, `DEI_STATUS_RESET);
        rd(`DEI_OFF_PATTERN_CHECK, `DEI_STATUS_RESET);
        rd(`DEI_OFF_CH0_EVENTS, `DEI_STATUS_RESET);
        rd(12'h100, 8'h00);
        for (k = 0; k < 8; k++) begin
            r = 8'($urandom());
            clk_c <= r;
            pat_c <= r;
            ch0_c <= r;
            tick(3);
            rd(`DEI_OFF_CLOCK_FIFO, r & 8'h3C);
            rd(`DEI_OFF_PATTERN_CHECK, r & `DEI_VALID_PATTERN_CHECK);
            rd(`DEI_OFF_CH0_EVENTS, r & `DEI_VALID_CH0_EVENTS);
            cmp_lvl(o_irq_n, 1'b1);
        end
        {clk_c, pat_c, ch0_c} <= 24'h000000;
        tick(2);
        {i_sticky_clock_fifo, i_sticky_pattern, i_sticky_ch0} <= 24'hFFFFFF;
        tick(2);
        {clk_c, pat_c, ch0_c} <= 24'hFFFFFF;
        tick(3);
        cmp_lvl(o_irq_n, 1'b0);
        {clk_c, pat_c, ch0_c} <= 24'h000000;
        tick(2);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h3C);
        rd(`DEI_OFF_PATTERN_CHECK, 8'h05);
        wr(`DEI_OFF_CH0_EVENTS, 8'h00);
        rd(`DEI_OFF_CH0_EVENTS, 8'hAF);
        wr(`DEI_OFF_CH0_EVENTS, 8'h01);
        rd(`DEI_OFF_CH0_EVENTS, 8'hAE);
        wr(12'h026, 8'hFF);
        wr(`DEI_OFF_CH0_EVENTS, 8'hFF);
        rd(`DEI_OFF_CH0_EVENTS, 8'h00);
        // A trip edge in the very cycle of a clear must survive it: the set takes priority.
        i_reg_wr <= 1'b1;
        i_reg_addr <= `DEI_OFF_CH0_EVENTS;
        i_reg_wdata <= 8'hFF;
        ch0_c <= 8'h01;
        tick(1);
        i_reg_wr <= 1'b0;
        ch0_c <= 8'h00;
        tick(1);
        rd(`DEI_OFF_CH0_EVENTS, 8'h01);
        wr(`DEI_OFF_CH0_EVENTS, 8'h01);
        rd(`DEI_OFF_CH0_EVENTS, 8'h00);
        wr(`DEI_OFF_PATTERN_CHECK, 8'hFF);
        tick(2);
        cmp_lvl(o_irq_n, 1'b0);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h3C);
        wr(`DEI_OFF_CLOCK_FIFO, 8'hFF);
        tick(2);
        cmp_lvl(o_irq_n, 1'b1);
        {i_sticky_clock_fifo, i_sticky_pattern, i_sticky_ch0} <= 24'h000000;
        i_link_en <= 1'b1;
        tick(3);
        k = $urandom_range(7, 0);
        i_lane_full <= 8'h01 << k;
        tick(4);
        cmp_lvl(o_lane_buffer_error_flag, 1'b1);
        rd(`DEI_OFF_LANE_FULL, 8'h01 << k);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h02);
        i_lane_full <= 8'h00;
        tick(4);
        cmp_lvl(o_lane_buffer_error_flag, 1'b1);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h02);
        i_link_en <= 1'b0;
        tick(4);
        cmp_lvl(o_lane_buffer_error_flag, 1'b0);
        i_link_en <= 1'b1;
        tick(4);
        cmp_lvl(o_lane_buffer_error_flag, 1'b0);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h00);
        i_lane_empty <= 8'h80 >> k;
        tick(4);
        cmp_lvl(o_lane_buffer_error_flag, 1'b1);
        rd(`DEI_OFF_LANE_EMPTY, 8'h80 >> k);
        // A reset in mid-run with the link on and faulted must restart the tracker from off.
        i_rstn <= 1'b0;
        tick(2);
        cmp_lvl(o_lane_buffer_error_flag, 1'b0);
        i_rstn <= 1'b1;
        tick(1);
        cmp_lvl(o_irq_n, 1'b1);
        rd(`DEI_OFF_CLOCK_FIFO, 8'h00);
        tick(2);
        cmp_lvl(o_lane_buffer_error_flag, 1'b1);
        i_lane_empty <= 8'h00;
        i_link_en <= 1'b0;
        tick(4);
        final_report();
    end
endmodule
